// ### src/lnb_status_pkg.sv
package lnb_status_pkg;

    // Register map reached over the two-wire serial port.
    localparam logic [7:0] FAULT_STATUS_ADDR = 8'h00;
    localparam logic [7:0] RESERVED_STATUS_ADDR = 8'h01;
    localparam logic [7:0] FAULT_STATUS_RESET = 8'h00;
    localparam logic [7:0] RESERVED_STATUS_RESET = 8'h00;

    // Field positions inside fault_status.
    localparam int unsigned OVERLOAD_BIT = 0;
    localparam int unsigned OVERTEMP_BIT = 6;
    localparam int unsigned LOW_INPUT_BIT = 7;

    // Slave address: upper six bits fixed, lowest bit from the address strap.
    localparam logic [5:0] SLAVE_ADDR_HI = 6'h04;

    // Serial engine counts.
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;

    // Pulsed overload retry timing.
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned OFF_TIME_MS = 900;
    localparam int unsigned ON_TIME_DIVISOR = 10;
    localparam int unsigned OFF_CYCLES_DEF = (CLK_HZ / 1000) * OFF_TIME_MS;
    localparam int unsigned ON_CYCLES_DEF = OFF_CYCLES_DEF / ON_TIME_DIVISOR;
    localparam int unsigned RETRY_CNT_W = 27;
    localparam logic [RETRY_CNT_W-1:0] RETRY_CNT_RESET = '0;

    localparam logic [3:0] LEVEL_SELECT_RESET = 4'h0;

    typedef logic [RETRY_CNT_W-1:0] retry_cnt_t;

    // Layout of fault_status, most significant field first.
    typedef struct packed {
        logic low_input_flag;
        logic overtemp_flag;
        logic [4:0] reserved;
        logic overload_flag;
    } fault_status_t;

    typedef enum logic [2:0] {
        RETRY_IDLE = 3'b001,
        RETRY_OFF = 3'b010,
        RETRY_ON = 3'b100
    } retry_state_t;

    typedef enum logic [6:0] {
        SER_IDLE = 7'b0000001,
        SER_ADDR = 7'b0000010,
        SER_ADDR_ACK = 7'b0000100,
        SER_WRITE = 7'b0001000,
        SER_WRITE_ACK = 7'b0010000,
        SER_READ = 7'b0100000,
        SER_READ_ACK = 7'b1000000
    } serial_state_t;

endpackage

// ### src/lnb_overload_retry.sv
module lnb_overload_retry
    import lnb_status_pkg::*;
#(
    parameter int unsigned OFF_CYCLES = OFF_CYCLES_DEF,
    parameter int unsigned ON_CYCLES = ON_CYCLES_DEF
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic overcurrent_in,
    input wire logic pulsed_limit_disable_in,
    output logic overload_flag_out,
    output logic stage_off_out
);

    localparam retry_cnt_t OFF_LAST = retry_cnt_t'(OFF_CYCLES - 1);
    localparam retry_cnt_t ON_LAST = retry_cnt_t'(ON_CYCLES - 1);

    retry_state_t state_q;
    retry_cnt_t cnt_q;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= RETRY_IDLE;
            cnt_q <= RETRY_CNT_RESET;
        end else begin
            case (state_q)
                RETRY_IDLE: begin
                    cnt_q <= RETRY_CNT_RESET;
                    if (overcurrent_in && !pulsed_limit_disable_in) begin // R11
                        state_q <= RETRY_OFF;
                    end
                end
                RETRY_OFF: begin
                    if (cnt_q == OFF_LAST) begin // R7
                        cnt_q <= RETRY_CNT_RESET;
                        state_q <= RETRY_ON;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                RETRY_ON: begin
                    if (cnt_q == ON_LAST) begin // R8
                        cnt_q <= RETRY_CNT_RESET;
                        state_q <= overcurrent_in ? RETRY_OFF : RETRY_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: begin
                    state_q <= RETRY_IDLE;
                    cnt_q <= RETRY_CNT_RESET;
                end
            endcase
        end
    end

    // The flag stays up for the whole retry cycle, not only while current is high.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            overload_flag_out <= 1'b0;
            stage_off_out <= 1'b0;
        end else begin
            overload_flag_out <= overcurrent_in || (state_q != RETRY_IDLE); // R2
            // Follows the next retry state, so every off phase lasts exactly OFF_CYCLES.
            stage_off_out <= (state_q == RETRY_OFF && cnt_q != OFF_LAST) ||
                (state_q == RETRY_IDLE && overcurrent_in && !pulsed_limit_disable_in) || // R7
                (state_q == RETRY_ON && cnt_q == ON_LAST && overcurrent_in); // R8
        end
    end

endmodule // lnb_overload_retry

// ### src/lnb_supply_status.sv
// Notes on behaviour
// R1 - Two status registers at 0x0 and 0x1, read only, writes never change them.
// R2 - Overload flag in bit 0 is 1 while current protection is triggered.
// R3 - Overtemperature flag bit 6 sets above 150 degrees, clears below 135.
// R4 - Low input flag bit 7 is 1 while supply is under the diagnostic threshold.
// R5 - All of status two and bits 1 to 5 of status one are reserved.
// R6 - Every status bit is zero after power-on.
// R7 - Shorted output with pulsed limiting is held off about 900 ms per retry.
// R8 - During retry the output is re-enabled for one tenth of the off time.
// R9 - Overload with overload latch set clears level selection and disables output.
// R10 - Overtemperature with thermal latch clears selection; otherwise selection returns after.
// R11 - Pulsed limiting runs when its disable bit is 0, not when it is 1.
// R12 - Flags mirror live conditions; reading never clears or changes them.
module lnb_supply_status
    import lnb_status_pkg::*;
#(
    parameter int unsigned OFF_CYCLES = OFF_CYCLES_DEF,
    parameter int unsigned ON_CYCLES = ON_CYCLES_DEF
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic addr_sel_in,
    input wire logic overcurrent_in,
    input wire logic overtemp_hot_in,
    input wire logic overtemp_cool_in,
    input wire logic low_power_diagnostic_in,
    input wire logic pulsed_limit_disable_in,
    input wire logic overload_latch_select_in,
    input wire logic thermal_latch_select_in,
    input wire logic [3:0] level_select_in,
    input wire logic level_select_wr_in,
    output logic [3:0] level_select_out,
    output logic output_enable_out
);

    fault_status_t status_q;
    logic overload_live;
    logic stage_off;
    logic overload_seen_q;
    logic overtemp_seen_q;
    logic [3:0] level_q;
    logic addr_lsb_q;
    logic strap_taken_q;
    logic scl_q;
    logic sda_q;
    logic start_cond;
    logic stop_cond;
    logic scl_rise;
    logic scl_fall;
    serial_state_t ser_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic read_q;
    logic ptr_set_q;
    logic [7:0] ptr_q;
    logic [7:0] read_val;

    // Only the two status registers are served here; other addresses read zero.
    function automatic logic [7:0] reg_read(input logic [7:0] addr, input fault_status_t st);
        logic [7:0] val;
        val = 8'h00;
        if (addr == FAULT_STATUS_ADDR) begin
            val = st; // R1
        end else if (addr == RESERVED_STATUS_ADDR) begin
            val = RESERVED_STATUS_RESET; // R5
        end
        return val;
    endfunction

    lnb_overload_retry #(
        .OFF_CYCLES(OFF_CYCLES),
        .ON_CYCLES(ON_CYCLES)
    ) u_retry (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .overcurrent_in(overcurrent_in),
        .pulsed_limit_disable_in(pulsed_limit_disable_in),
        .overload_flag_out(overload_live),
        .stage_off_out(stage_off)
    );

    // Status flags follow live conditions only; no bus access touches them.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            status_q <= FAULT_STATUS_RESET; // R6
        end else begin
            status_q.overload_flag <= overload_live; // R2 R12
            status_q.low_input_flag <= low_power_diagnostic_in; // R4
            status_q.reserved <= '0; // R5
            if (overtemp_hot_in) begin
                status_q.overtemp_flag <= 1'b1; // R3
            end else if (overtemp_cool_in) begin
                status_q.overtemp_flag <= 1'b0; // R3
            end
        end
    end

    // Protection clears beat a host write in the same cycle.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            level_q <= LEVEL_SELECT_RESET;
            overload_seen_q <= 1'b0;
            overtemp_seen_q <= 1'b0;
        end else begin
            overload_seen_q <= status_q.overload_flag;
            overtemp_seen_q <= status_q.overtemp_flag;
            if (status_q.overload_flag && !overload_seen_q && overload_latch_select_in) begin
                level_q <= LEVEL_SELECT_RESET; // R9
            end else if (status_q.overtemp_flag && !overtemp_seen_q &&
                         thermal_latch_select_in) begin
                level_q <= LEVEL_SELECT_RESET; // R10
            end else if (level_select_wr_in) begin
                level_q <= level_select_in;
            end
        end
    end

    // With the thermal latch clear the held selection simply comes back after cooling.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            level_select_out <= LEVEL_SELECT_RESET;
            output_enable_out <= 1'b0;
        end else begin
            level_select_out <= level_q;
            output_enable_out <= (level_q != LEVEL_SELECT_RESET) && !stage_off && // R7 R8
                !status_q.overtemp_flag && // R10
                !(status_q.overload_flag && overload_latch_select_in); // R9
        end
    end

    // The address strap is taken once, on the first edge after reset release.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            addr_lsb_q <= 1'b0;
            strap_taken_q <= 1'b0;
        end else if (!strap_taken_q) begin
            addr_lsb_q <= addr_sel_in;
            strap_taken_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    assign read_val = reg_read(ptr_q, status_q);
    assign start_cond = scl_in && scl_q && sda_q && !sda_in;
    assign stop_cond = scl_in && scl_q && !sda_q && sda_in;
    assign scl_rise = scl_in && !scl_q;
    assign scl_fall = !scl_in && scl_q;

    // Open drain: the data line is only ever pulled low, so its level flop stays zero.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ser_q <= SER_IDLE;
            bit_cnt_q <= BIT_CNT_RESET;
            shift_q <= 8'h00;
            read_q <= 1'b0;
            ptr_set_q <= 1'b0;
            ptr_q <= FAULT_STATUS_ADDR;
            sda_oe_out <= 1'b0;
        end else if (start_cond) begin
            ser_q <= SER_ADDR;
            bit_cnt_q <= BIT_CNT_RESET;
            ptr_set_q <= 1'b0;
            sda_oe_out <= 1'b0;
        end else if (stop_cond) begin
            ser_q <= SER_IDLE;
            sda_oe_out <= 1'b0;
        end else begin
            case (ser_q)
                SER_IDLE: begin
                    sda_oe_out <= 1'b0;
                end
                SER_ADDR, SER_WRITE: begin
                    if (scl_rise && bit_cnt_q != BYTE_BITS) begin
                        shift_q <= {shift_q[6:0], sda_in};
                        bit_cnt_q <= bit_cnt_q + 1'b1;
                    end else if (scl_fall && bit_cnt_q == BYTE_BITS) begin
                        bit_cnt_q <= BIT_CNT_RESET;
                        if (ser_q == SER_WRITE) begin
                            // Only the first written byte moves the pointer; later bytes and status stay put.
                            if (!ptr_set_q) begin
                                ptr_q <= shift_q; // R1
                                ptr_set_q <= 1'b1;
                            end
                            ser_q <= SER_WRITE_ACK;
                            sda_oe_out <= 1'b1;
                        end else if (shift_q[7:1] == {SLAVE_ADDR_HI, addr_lsb_q}) begin
                            read_q <= shift_q[0];
                            ser_q <= SER_ADDR_ACK;
                            sda_oe_out <= 1'b1;
                        end else begin
                            ser_q <= SER_IDLE;
                        end
                    end
                end
                SER_ADDR_ACK, SER_WRITE_ACK: begin
                    if (scl_fall) begin
                        if (read_q) begin
                            shift_q <= read_val; // R12
                            sda_oe_out <= !read_val[7];
                            bit_cnt_q <= 4'h1;
                            ser_q <= SER_READ;
                        end else begin
                            sda_oe_out <= 1'b0;
                            ser_q <= SER_WRITE;
                        end
                    end
                end
                SER_READ: begin
                    if (scl_fall) begin
                        if (bit_cnt_q == BYTE_BITS) begin
                            sda_oe_out <= 1'b0;
                            bit_cnt_q <= BIT_CNT_RESET;
                            ptr_q <= ptr_q + 1'b1;
                            ser_q <= SER_READ_ACK;
                        end else begin
                            sda_oe_out <= !shift_q[6];
                            shift_q <= {shift_q[6:0], 1'b0};
                            bit_cnt_q <= bit_cnt_q + 1'b1;
                        end
                    end
                end
                SER_READ_ACK: begin
                    if (scl_rise && sda_in) begin
                        ser_q <= SER_IDLE;
                    end else if (scl_rise) begin
                        ser_q <= SER_ADDR_ACK;
                    end
                end
                default: begin
                    ser_q <= SER_IDLE;
                    sda_oe_out <= 1'b0;
                end
            endcase
        end
    end

endmodule // lnb_supply_status

// ### tb/lnb_status_monitor.sv
module lnb_status_monitor #(
    parameter int unsigned OFF_CYCLES = 50,
    parameter int unsigned ON_CYCLES = 5
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic sda_out,
    input wire logic overcurrent_in,
    input wire logic overtemp_hot_in,
    input wire logic overtemp_cool_in,
    input wire logic pulsed_limit_disable_in,
    input wire logic overload_latch_select_in,
    input wire logic level_select_wr_in,
    input wire logic [3:0] level_select_out,
    input wire logic output_enable_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] quiet_q;
    logic [31:0] on_q;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // Counts cycles without overcurrent, so a new retry is known to start from idle.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) quiet_q <= '0;
        else if (overcurrent_in) quiet_q <= '0;
        else if (quiet_q != 32'hffff_ffff) quiet_q <= quiet_q + 32'h1;
    end
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            on_q <= '0;
        end else if (output_enable_out && overcurrent_in && !pulsed_limit_disable_in) begin
            on_q <= on_q + 32'h1;
        end else begin
            on_q <= '0;
        end
    end
    sequence s_hot_hold;
        overtemp_hot_in [*3];
    endsequence
    sequence s_ovl_latch;
        $rose(overcurrent_in) ##0 (overcurrent_in && overload_latch_select_in
            && pulsed_limit_disable_in && !level_select_wr_in) [*6];
    endsequence
    a_sda_open_drain: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    a_hot_disables: assert property (s_hot_hold |-> !output_enable_out)
        else $error("output on while hot");
    a_no_sel_off: assert property ((level_select_out == 4'h0) [*2] |-> !output_enable_out)
        else $error("output on without selection");
    a_ovl_clears_sel: assert property (s_ovl_latch |-> level_select_out == 4'h0)
        else $error("selection kept after latched overload");
    a_retry_starts: assert property (quiet_q > OFF_CYCLES + ON_CYCLES && overcurrent_in
        && !pulsed_limit_disable_in |-> ##[1:4] !output_enable_out)
        else $error("retry did not switch output off");
    a_retry_on_span: assert property (on_q <= ON_CYCLES)
        else $error("retry on phase too long");
    a_retry_off_hold: assert property ($fell(output_enable_out) && overcurrent_in
        && !pulsed_limit_disable_in |-> !output_enable_out [*8])
        else $error("retry off phase too short");
    a_pulse_disabled: assert property ((pulsed_limit_disable_in && !overload_latch_select_in
        && overtemp_cool_in && !overtemp_hot_in && level_select_out != 4'h0) [*4]
        |-> output_enable_out)
        else $error("output off with retry disabled");
endmodule // lnb_status_monitor

bind lnb_supply_status lnb_status_monitor #(.OFF_CYCLES(OFF_CYCLES), .ON_CYCLES(ON_CYCLES)) mon_u (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .sda_out(sda_out),
    .overcurrent_in(overcurrent_in), .overtemp_hot_in(overtemp_hot_in),
    .overtemp_cool_in(overtemp_cool_in), .pulsed_limit_disable_in(pulsed_limit_disable_in),
    .overload_latch_select_in(overload_latch_select_in), .level_select_wr_in(level_select_wr_in),
    .level_select_out(level_select_out), .output_enable_out(output_enable_out)
);

// ### tb/i2c_host_model.sv
module i2c_host_model (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out,
    output logic [7:0] rd_byte_out,
    output logic rd_stb_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
        rd_byte_out = 8'h00;
        rd_stb_out = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic start();
        sda_low_out <= 1'b0;
        tick(3);
        scl_out <= 1'b1;
        tick(3);
        sda_low_out <= 1'b1;
        tick(3);
        scl_out <= 1'b0;
        tick(2);
    endtask
    task automatic stop();
        sda_low_out <= 1'b1;
        tick(3);
        scl_out <= 1'b1;
        tick(3);
        sda_low_out <= 1'b0;
        tick(3);
    endtask
    // Eight bits MSB first, then the acknowledge slot driven with m.
    task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
        logic [8:0] s;
        for (int i = 8; i >= 0; i--) begin
            sda_low_out <= (i > 0) ? !d[i-1] : !m;
            tick(3);
            scl_out <= 1'b1;
            tick(2);
            s[i] = sda_in;
            tick(2);
            scl_out <= 1'b0;
            tick(1);
        end
        q = s[8:1];
        a = s[0];
    endtask
    task automatic rbyte(input logic m);
        logic [7:0] q;
        logic a;
        xfer(8'hff, m, q, a);
        rd_byte_out <= q;
        rd_stb_out <= 1'b1;
        tick(1);
        rd_stb_out <= 1'b0;
    endtask
endmodule // i2c_host_model

// ### tb/tb_top.sv
module tb_top
    import lnb_status_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OFF = 50;
    localparam int ON = 5;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic scl, sda, host_low, sda_oe, sda_o, rd_stb, en;
    logic oc = 1'b0, hot = 1'b0, cool = 1'b1, low_power_diagnostic = 1'b0, pld = 1'b1;
    logic olat = 1'b0, tlat = 1'b0, wr = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [3:0] lvl;
    logic [7:0] rd_byte;
    logic [7:0] exp_q[$];
    int err_count = 0;
    int total_checks = 0;
    always #4 sys_clk = !sys_clk;
    assign sda = !(sda_oe || host_low);
    lnb_supply_status #(.OFF_CYCLES(OFF), .ON_CYCLES(ON)) dut_u (
        .sys_clk_in(sys_clk), .rst_in(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
        .sda_oe_out(sda_oe), .addr_sel_in(1'b1), .overcurrent_in(oc), .overtemp_hot_in(hot),
        .overtemp_cool_in(cool), .low_power_diagnostic_in(low_power_diagnostic), .pulsed_limit_disable_in(pld),
        .overload_latch_select_in(olat), .thermal_latch_select_in(tlat), .level_select_in(sel),
        .level_select_wr_in(wr), .level_select_out(lvl), .output_enable_out(en));
    i2c_host_model host_u (.clk_in(sys_clk), .sda_in(sda), .scl_out(scl), .sda_low_out(host_low),
        .rd_byte_out(rd_byte), .rd_stb_out(rd_stb));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic close_out();
        if (err_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic run_len(input logic v, output int n);
        n = 0;
        while (en === v && n < 250) begin
            n++;
            @(negedge sys_clk);
        end
        if (n >= 250) begin
            err_count++;
            close_out();
        end
    endtask
    task automatic rd(input logic [7:0] p, input int n);
        logic [7:0] q;
        logic a;
        host_u.start();
        host_u.xfer({SLAVE_ADDR_HI, 1'b1, 1'b0}, 1'b1, q, a);
        chk({7'h00, a}, 8'h00);
        host_u.xfer(p, 1'b1, q, a);
        host_u.start();
        host_u.xfer({SLAVE_ADDR_HI, 1'b1, 1'b1}, 1'b1, q, a);
        for (int k = 0; k < n; k++) host_u.rbyte(k == n - 1);
        host_u.stop();
    endtask
    task automatic setsel(input logic [3:0] v);
        sel <= v;
        wr <= 1'b1;
        step(1);
        wr <= 1'b0;
        step(4);
        chk({3'h0, en, lvl}, {4'h1, v});
    endtask
    // Each read byte is paired with the oldest expected value.
    always @(posedge sys_clk) if (rd_stb === 1'b1) begin
        chk(rd_byte, exp_q.size() > 0 ? exp_q.pop_front() : 8'hee);
    end
    initial begin
        #400000;
        err_count++;
        close_out();
    end
    initial begin
        logic [7:0] q;
        logic a;
        logic [31:0] seed;
        int n;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        step(3);
        chk({4'h0, lvl}, 8'h00);
        for (int k = 0; k < 2; k++) exp_q.push_back(8'h00);
        rd(8'h00, 2);
        {low_power_diagnostic, hot, cool, oc, pld} <= 5'b11011;
        step(4);
        for (int k = 0; k < 3; k++) exp_q.push_back(k > 0 ? 8'h00 : 8'hc1);
        rd(8'h00, 3);
        host_u.start();
        host_u.xfer({SLAVE_ADDR_HI, 1'b1, 1'b0}, 1'b1, q, a);
        host_u.xfer(8'h00, 1'b1, q, a);
        host_u.xfer(8'h3e, 1'b1, q, a);
        host_u.stop();
        hot <= 1'b0;
        exp_q.push_back(8'hc1);
        rd(8'h00, 1);
        {low_power_diagnostic, hot, cool, oc, pld} <= 5'b00101;
        step(4);
        exp_q.push_back(8'h00);
        rd(8'h00, 1);
        host_u.start();
        host_u.xfer({SLAVE_ADDR_HI, 1'b0, 1'b1}, 1'b1, q, a);
        chk({7'h00, a}, 8'h01);
        host_u.stop();
        seed = lfsr(32'h467f);
        setsel(seed[3:0] | 4'h1);
        {hot, cool} <= 2'b10;
        step(5);
        chk({3'h0, en, lvl}, {4'h0, seed[3:0] | 4'h1});
        {hot, cool} <= 2'b01;
        step(5);
        chk({3'h0, en, lvl}, {4'h1, seed[3:0] | 4'h1});
        tlat <= 1'b1;
        {hot, cool} <= 2'b10;
        step(5);
        chk({3'h0, en, lvl}, 8'h00);
        {hot, cool} <= 2'b01;
        seed = lfsr(seed);
        setsel(seed[3:0] | 4'h1);
        olat <= 1'b1;
        oc <= 1'b1;
        step(8);
        oc <= 1'b0;
        step(6);
        chk({3'h0, en, lvl}, 8'h00);
        setsel(seed[3:0] | 4'h1);
        olat <= 1'b0;
        oc <= 1'b1;
        step(20);
        chk({3'h0, en, lvl}, {4'h1, seed[3:0] | 4'h1});
        oc <= 1'b0;
        step(4);
        pld <= 1'b0;
        step(70);
        oc <= 1'b1;
        run_len(1'b1, n);
        run_len(1'b0, n);
        chk(8'(n), 8'(OFF));
        run_len(1'b1, n);
        chk(8'(n), 8'(ON));
        run_len(1'b0, n);
        chk(8'(n), 8'(OFF));
        oc <= 1'b0;
        step(80);
        chk(8'(exp_q.size()), 8'h00);
        close_out();
    end
endmodule // tb_top
